// ===== verilog/fsk_ook_shaping_demod_sync.sv
`timescale 1ns/1ns
`default_nettype none
module fsk_ook_shaping_demod_sync (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    link_clk,
  input  wire logic                    link_rst_n,
  input  wire modem_pkg::link_sample_t link_sample,
  input  wire modem_pkg::modem_cfg_t   cfg,
  input  wire logic                    fei_start,
  input  wire logic                    general_pin_2_in,
  output logic                         general_pin_2_out,
  output logic                         general_pin_2_oe,
  output logic                         bit_clock_out,
  output logic                         general_pin_1_out,
  output logic [9:0]                   tx_mod_out,
  output logic [7:0]                   pa_level_out,
  output logic                         rx_data_out,
  output modem_pkg::fei_status_t       fei_status
);
  import modem_pkg::*;

  typedef struct packed {
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
    link_sample_t hold;
  } link_state_t;

  typedef struct packed {
    logic               din_s1;
    logic               din_s2;
    logic               req_s1;
    logic               req_s2;
    logic               seen;
    link_sample_t       smp;
    logic               smp_new;
    logic [16:0]        br_cnt;
    logic [3:0]         frac_acc;
    logic [2:0]         tx_hist;
    logic [9:0]         tx_mod;
    logic [7:0]         pa_level;
    logic [7:0]         ramp_cnt;
    logic               tx_clk;
    logic [7:0]         peak;
    logic [7:0]         avg;
    logic [11:0]        dec_cnt;
    logic               slice;
    logic [16:0]        ph_cnt;
    logic               prev_d;
    logic               rx_data;
    logic               rx_clk;
    logic               fei_busy;
    logic [2:0]         fei_bits;
    logic signed [19:0] fei_acc;
    logic signed [15:0] fei_result;
    logic               fei_done;
    logic               pin2_out;
    logic               pin2_oe;
    logic               bclk;
  } sys_state_t;

  link_state_t l_reg, l_next;
  sys_state_t  s_reg, s_next;

  // Link side: a new sample is captured only once the previous one was
  // acknowledged, so the held word is stable while the sys side copies it.
  // Samples that arrive during the round trip are dropped on purpose.
  always_comb begin
    l_next = l_reg;
    l_next.ack_s1 = s_reg.seen;
    l_next.ack_s2 = l_reg.ack_s1;
    if (l_reg.ack_s2 == l_reg.req) begin
      l_next.hold = link_sample;
      l_next.req  = ~l_reg.req;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  logic [16:0] period;
  logic [16:0] half;
  logic        bit_tick;
  logic        carry;
  logic [4:0]  frac_sum;
  logic        demod_bit;
  logic        sync_on;
  logic        gauss_on;
  logic [7:0]  thresh;
  logic [7:0]  peak_thr;
  logic [8:0]  peak_dec;
  logic [7:0]  w_edge;
  logic [7:0]  w_mid;
  logic signed [9:0] acc_mod;
  logic [7:0]  pa_target;
  logic [11:0] dec_limit;
  logic [8:0]  avg_diff;
  logic [8:0]  floor_off;

  always_comb begin
    s_next = s_reg;
    s_next.din_s1 = general_pin_2_in;
    s_next.din_s2 = s_reg.din_s1;
    s_next.req_s1 = l_reg.req;
    s_next.req_s2 = s_reg.req_s1;
    s_next.smp_new = 1'b0;
    if (s_reg.req_s2 != s_reg.seen) begin
      s_next.seen    = s_reg.req_s2;
      s_next.smp     = l_reg.hold;
      s_next.smp_new = 1'b1;
    end

    // Bit period; fraction adds one cycle on accumulator carry
    // The sync phase counter ignores the fraction; data edges realign it
    frac_sum = {1'b0, s_reg.frac_acc} + {1'b0, (cfg.ook_mode ? 4'h0 : cfg.bitrate_fraction)};
    carry    = frac_sum[4];
    period   = {1'b0, cfg.bitrate_high_byte, cfg.bitrate_low_byte};
    if (period == 17'h0_0000) begin
      period = 17'h0_0001;
    end
    half     = period >> 1;
    bit_tick = (s_reg.br_cnt >= period - 17'h0_0001 + {16'h0000, carry});
    if (bit_tick) begin
      s_next.br_cnt   = 17'h0_0000;
      s_next.frac_acc = frac_sum[3:0];
    end else begin
      s_next.br_cnt = s_reg.br_cnt + 17'h0_0001;
    end

    // TX Gaussian shaping over a three-bit window
    // Weights sum to eight in both settings, so peak deviation stays put
    gauss_on = !cfg.ook_mode && cfg.tx_shaping_setting && (cfg.shaping_ctrl_field != SHAPE_OFF);
    if (cfg.shaping_ctrl_field == SHAPE_BT05) begin
      w_edge = {4'h0, G_BT05_EDGE};
      w_mid  = {4'h0, G_BT05_MID};
    end else begin
      w_edge = {4'h0, G_BT1_EDGE};
      w_mid  = {4'h0, G_BT1_MID};
    end
    acc_mod = '0;
    acc_mod = s_reg.tx_hist[0] ? acc_mod + $signed({2'b00, w_edge}) : acc_mod - $signed({2'b00, w_edge});
    acc_mod = s_reg.tx_hist[1] ? acc_mod + $signed({2'b00, w_mid}) : acc_mod - $signed({2'b00, w_mid});
    acc_mod = s_reg.tx_hist[2] ? acc_mod + $signed({2'b00, w_edge}) : acc_mod - $signed({2'b00, w_edge});
    if (cfg.tx_enable) begin
      if (gauss_on) begin
        // Data is taken at the clock edge after the one the processor answered
        if (bit_tick) begin
          s_next.tx_clk  = 1'b1;
          s_next.tx_hist = {s_reg.tx_hist[1:0], s_reg.din_s2};
        end else if (s_reg.br_cnt == half) begin
          s_next.tx_clk = 1'b0;
        end
        s_next.tx_mod = acc_mod;
      end else begin
        // Without filtering the data pin feeds the modulator directly
        s_next.tx_clk  = 1'b0;
        s_next.tx_hist = {3{s_reg.din_s2}};
        s_next.tx_mod  = s_reg.din_s2 ? {2'b00, w_mid + w_edge + w_edge} : -{2'b00, w_mid + w_edge + w_edge};
      end
    end else begin
      s_next.tx_clk = 1'b0;
      s_next.tx_mod = '0;
      // Filter history restarts clean on the next transmit
      s_next.tx_hist = '0;
    end

    // OOK PA ramp; abrupt switching only when shaping is off
    // Ramp tick is fixed in time, so the ramp length ignores the bit rate
    pa_target = (cfg.tx_enable && cfg.ook_mode && s_reg.din_s2) ? PA_LEVEL_MAX : 8'h00;
    if (!cfg.tx_shaping_setting || cfg.shaping_ctrl_field == SHAPE_OFF) begin
      s_next.pa_level = pa_target;
      s_next.ramp_cnt = '0;
    end else if (s_reg.ramp_cnt >= 8'(RAMP_TICK_CYC - 1)) begin
      s_next.ramp_cnt = '0;
      if (s_reg.pa_level < pa_target) begin
        s_next.pa_level = (pa_target - s_reg.pa_level > PA_RAMP_STEP) ? s_reg.pa_level + PA_RAMP_STEP : pa_target;
      end else if (s_reg.pa_level > pa_target) begin
        s_next.pa_level = (s_reg.pa_level - pa_target > PA_RAMP_STEP) ? s_reg.pa_level - PA_RAMP_STEP : pa_target;
      end
    end else begin
      s_next.ramp_cnt = s_reg.ramp_cnt + 8'h01;
    end

    // OOK slicer thresholds
    // Nine-bit sum so a high floor cannot wrap the offset compare
    floor_off = {1'b0, cfg.slicer_floor_level} + {1'b0, PEAK_OFFSET};
    if ({1'b0, s_reg.peak} > floor_off) begin
      peak_thr = s_reg.peak - PEAK_OFFSET;
    end else begin
      peak_thr = cfg.slicer_floor_level;
    end
    // Unknown slicer codes fall back to the fixed floor
    case (cfg.onoff_slicer_type)
      SLICE_PEAK:    thresh = peak_thr;
      SLICE_FIXED:   thresh = cfg.slicer_floor_level;
      SLICE_AVERAGE: thresh = s_reg.avg;
      default:       thresh = cfg.slicer_floor_level;
    endcase
    dec_limit = 12'(({9'h000, cfg.peak_decay_period} + 12'h001) * 12'(DECAY_UNIT_CYC)) - 12'h001;
    peak_dec  = {1'b0, s_reg.peak} - {6'h00, cfg.peak_decay_step};
    avg_diff  = '0;
    if (s_reg.smp_new) begin
      s_next.slice = s_reg.smp.rssi > thresh;
      // Arithmetic shift by three moves an eighth of the error per sample
      avg_diff     = {1'b0, s_reg.smp.rssi} - {1'b0, s_reg.avg};
      s_next.avg   = s_reg.avg + {{3{avg_diff[8]}}, avg_diff[7:3]};
      if (s_reg.smp.rssi > s_reg.peak) begin
        s_next.peak = s_reg.smp.rssi;
      end
    end
    // Decay is paced by its own counter, not by the bit rate
    if (s_reg.dec_cnt >= dec_limit) begin
      s_next.dec_cnt = '0;
      // Decay only while the slicer sees no carrier or a zero
      if (!s_reg.slice && !(s_reg.smp_new && s_reg.smp.rssi > s_reg.peak)) begin
        if (peak_dec[8] || peak_dec[7:0] < cfg.slicer_floor_level) begin
          s_next.peak = cfg.slicer_floor_level;
        end else begin
          s_next.peak = peak_dec[7:0];
        end
      end
    end else begin
      s_next.dec_cnt = s_reg.dec_cnt + 12'h001;
    end

    // Bit synchronizer: realign phase on each data edge, sample mid-bit
    // Samples arrive decimated, so edges jitter by one handshake round
    demod_bit = cfg.ook_mode ? s_reg.slice : s_reg.smp.fsk_bit;
    sync_on   = cfg.packet_mode || !cfg.sync_bypass;
    s_next.prev_d = demod_bit;
    // Realigning on every edge absorbs a few percent of rate error
    if (demod_bit != s_reg.prev_d) begin
      s_next.ph_cnt = 17'h0_0000;
    end else if (s_reg.ph_cnt >= period - 17'h0_0001) begin
      s_next.ph_cnt = 17'h0_0000;
    end else begin
      s_next.ph_cnt = s_reg.ph_cnt + 17'h0_0001;
    end
    if (sync_on) begin
      if (s_reg.ph_cnt == half && demod_bit == s_reg.prev_d) begin
        s_next.rx_data = demod_bit;
        s_next.rx_clk  = 1'b1;
      end else if (s_reg.ph_cnt == 17'h0_0000) begin
        s_next.rx_clk = 1'b0;
      end
    end else begin
      s_next.rx_data = demod_bit;
      s_next.rx_clk  = 1'b0;
    end

    // Pins: TX owns the clock pin in Gaussian mode, RX drives data out
    // Pin 2 is released while transmitting so the processor can drive it
    if (cfg.tx_enable) begin
      s_next.bclk     = gauss_on ? s_reg.tx_clk : 1'b0;
      s_next.pin2_oe  = 1'b0;
      s_next.pin2_out = 1'b0;
    end else begin
      s_next.bclk     = s_reg.rx_clk;
      s_next.pin2_oe  = 1'b1;
      s_next.pin2_out = s_reg.rx_data;
    end

    // Frequency error: sum of discriminator samples over the window, shifted right by two
    // A start while busy is dropped, the running window is kept
    // Four guard bits: up to sixteen full-scale samples cannot overflow
    s_next.fei_done = 1'b0;
    if (!s_reg.fei_busy) begin
      if (fei_start) begin
        s_next.fei_busy = 1'b1;
        s_next.fei_bits = '0;
        s_next.fei_acc  = '0;
      end
    end else begin
      if (s_reg.smp_new) begin
        s_next.fei_acc = s_reg.fei_acc + {{4{s_reg.smp.freq_err[15]}}, s_reg.smp.freq_err};
      end
      if (bit_tick) begin
        if (s_reg.fei_bits == 3'(FEI_BIT_PERIODS - 1)) begin
          s_next.fei_busy = 1'b0;
          s_next.fei_done = 1'b1;
          // Result counts are synth steps, signed
          s_next.fei_result = s_reg.fei_acc[FEI_SHIFT +: 16];
        end else begin
          s_next.fei_bits = s_reg.fei_bits + 3'h1;
        end
      end
    end
  end

  // Result reset value is named so software sees a defined word
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg            <= '0;
      s_reg.smp.rssi   <= RSSI_RESET;
      s_reg.fei_result <= RESULT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign general_pin_2_out = s_reg.pin2_out;
  assign general_pin_2_oe  = s_reg.pin2_oe;
  assign bit_clock_out     = s_reg.bclk;
  // Pin 1 mirrors the bit clock from the same flip-flop
  assign general_pin_1_out = s_reg.bclk;
  assign tx_mod_out        = s_reg.tx_mod;
  assign pa_level_out      = s_reg.pa_level;
  assign rx_data_out       = s_reg.rx_data;
  assign fei_status        = '{busy: s_reg.fei_busy, done: s_reg.fei_done, freq_error_result: s_reg.fei_result};
endmodule
`default_nettype wire

// ===== inc/modem_pkg.sv
package modem_pkg;
  localparam int SYS_CLK_NS    = 8;
  localparam int RAMP_TICK_NS  = 200;
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int DECAY_UNIT_NS = 1000;
  localparam int DECAY_UNIT_CYC = (DECAY_UNIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int FEI_BIT_PERIODS = 4;
  localparam int FEI_SHIFT       = 2;
  localparam int PREAMBLE_MIN_BITS = 12;
  localparam int MAX_RUN_BITS      = 16;
  localparam logic [7:0] PEAK_OFFSET  = 8'h0C;
  localparam logic [7:0] PA_LEVEL_MAX = 8'hFF;
  localparam logic [7:0] PA_RAMP_STEP = 8'h10;
  localparam logic [1:0] SHAPE_OFF  = 2'h0;
  localparam logic [1:0] SHAPE_BT1  = 2'h1;
  localparam logic [1:0] SHAPE_BT05 = 2'h2;
  localparam logic [3:0] G_BT1_EDGE  = 4'h1;
  localparam logic [3:0] G_BT1_MID   = 4'h6;
  localparam logic [3:0] G_BT05_EDGE = 4'h2;
  localparam logic [3:0] G_BT05_MID  = 4'h4;
  localparam logic [7:0] RSSI_RESET  = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SLICE_FIXED   = 3'b001,
    SLICE_PEAK    = 3'b010,
    SLICE_AVERAGE = 3'b100
  } onoff_slicer_type_t;

  typedef struct packed {
    logic               ook_mode;
    logic               packet_mode;
    logic               tx_enable;
    logic               sync_bypass;
    logic [1:0]         shaping_ctrl_field;
    logic               tx_shaping_setting;
    onoff_slicer_type_t onoff_slicer_type;
    logic [2:0]         peak_decay_step;
    logic [2:0]         peak_decay_period;
    logic [7:0]         slicer_floor_level;
    logic [7:0]         bitrate_high_byte;
    logic [7:0]         bitrate_low_byte;
    logic [3:0]         bitrate_fraction;
  } modem_cfg_t;

  typedef struct packed {
    logic [7:0]  rssi;
    logic        fsk_bit;
    logic [15:0] freq_err;
  } link_sample_t;

  typedef struct packed {
    logic               busy;
    logic               done;
    logic signed [15:0] freq_error_result;
  } fei_status_t;
endpackage

// ===== verif/demod_checker.sv
`timescale 1ns/1ns
`default_nettype none
module demod_checker (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire modem_pkg::modem_cfg_t  cfg,
  input wire logic                   fei_start,
  input wire logic                   general_pin_2_out,
  input wire logic                   general_pin_2_oe,
  input wire logic                   bit_clock_out,
  input wire logic                   general_pin_1_out,
  input wire logic [9:0]             tx_mod_out,
  input wire logic [7:0]             pa_level_out,
  input wire logic                   rx_data_out,
  input wire modem_pkg::fei_status_t fei_status
);
  import modem_pkg::*;
  localparam int FEI_MAX = 170;
  modem_cfg_t cfg_q;
  logic [3:0] age;
  // Config edges leave short legal transients, so checks wait for a settled config
  always_ff @(posedge sys_clk) begin
    cfg_q <= cfg;
    if (!rst_n || cfg != cfg_q)
      age <= 4'h0;
    else if (age != 4'hF)
      age <= age + 4'h1;
  end
  wire logic quiet = age == 4'hF && cfg == cfg_q;
  wire logic shaped = cfg.tx_shaping_setting && cfg.shaping_ctrl_field != SHAPE_OFF;
  wire logic gtx = quiet && cfg.tx_enable && !cfg.ook_mode && shaped;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_oe_dir; $past(rst_n) |-> general_pin_2_oe == !$past(cfg.tx_enable); endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin 2 direction wrong");
  property p_pin2; $past(rst_n) && general_pin_2_oe |-> general_pin_2_out == $past(rx_data_out); endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 data not rx data");
  property p_byp; quiet && cfg.sync_bypass && !cfg.packet_mode && !cfg.tx_enable |-> !bit_clock_out; endproperty
  a_byp: assert property (p_byp) else $error("bit clock runs in bypass");
  property p_pin1; general_pin_1_out == bit_clock_out; endproperty
  a_pin1: assert property (p_pin1) else $error("pin 1 not the bit clock");
  property p_start; fei_start && !fei_status.busy |=> fei_status.busy; endproperty
  a_start: assert property (p_start) else $error("measurement not started");
  property p_fei_time; $rose(fei_status.busy) |-> ##[1:FEI_MAX] fei_status.done; endproperty
  a_fei_time: assert property (p_fei_time) else $error("measurement too long");
  property p_done; fei_status.done |-> !fei_status.busy && $past(fei_status.busy) ##1 !fei_status.done; endproperty
  a_done: assert property (p_done) else $error("done pulse malformed");
  property p_hold; $past(rst_n) && !fei_status.done |-> $stable(fei_status.freq_error_result); endproperty
  a_hold: assert property (p_hold) else $error("result changed without done");
  property p_raw;
    quiet && cfg.tx_enable && !cfg.ook_mode && !cfg.tx_shaping_setting |-> tx_mod_out inside {10'h008, 10'h3F8};
  endproperty
  a_raw: assert property (p_raw) else $error("unshaped word wrong");
  property p_bt05;
    gtx && cfg.shaping_ctrl_field == SHAPE_BT05 |-> tx_mod_out inside {10'h000, 10'h004, 10'h008, 10'h3FC, 10'h3F8};
  endproperty
  a_bt05: assert property (p_bt05) else $error("narrow filter word wrong");
  property p_ramp;
    quiet && cfg.tx_enable && cfg.ook_mode && shaped && $changed(pa_level_out) |->
      (pa_level_out > $past(pa_level_out) ? pa_level_out - $past(pa_level_out) :
       $past(pa_level_out) - pa_level_out) <= PA_RAMP_STEP ##1 $stable(pa_level_out) [*8];
  endproperty
  a_ramp: assert property (p_ramp) else $error("bias step too abrupt");
  c_done: cover property (fei_status.done);
  c_pkt: cover property (quiet && cfg.packet_mode && $rose(bit_clock_out));
  c_gtx: cover property (gtx && $changed(tx_mod_out));
endmodule
bind fsk_ook_shaping_demod_sync demod_checker u_demod_checker (
  .sys_clk, .rst_n, .cfg, .fei_start, .general_pin_2_out, .general_pin_2_oe, .bit_clock_out, .general_pin_1_out,
  .tx_mod_out, .pa_level_out, .rx_data_out, .fei_status
);
`default_nettype wire

// ===== verif/mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  input  wire logic bit_clock_out,
  input  wire logic alt,
  input  wire logic level,
  output logic      data_out
);
  logic nxt = 1'b0;
  // New bit is ready on the request edge, well before the device samples it
  always @(posedge bit_clock_out) nxt <= ~nxt;
  assign data_out = alt ? nxt : level;
endmodule
`default_nettype wire

// ===== verif/fsk_ook_shaping_demod_sync_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fsk_ook_shaping_demod_sync_bench;
  import modem_pkg::*;
  logic         sys_clk = 1'b0;
  logic         link_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         link_rst_n = 1'b0;
  link_sample_t link_sample = '0;
  modem_cfg_t   cfg;
  logic         fei_start = 1'b0;
  logic         alt = 1'b0;
  logic         level = 1'b0;
  logic         tog = 1'b0;
  logic         fsk_v = 1'b0;
  logic [7:0]   rssi_v = 8'h00;
  logic [15:0]  ferr_v = 16'h0000;
  logic         mcu_data;
  logic         general_pin_2_out;
  logic         general_pin_2_oe;
  logic         bit_clock_out;
  logic [9:0]   tx_mod_out;
  logic [7:0]   pa_level_out;
  logic         rx_data_out;
  fei_status_t  fei_status;
  int           fails = 0;
  int           checked = 0;
  int           cyc = 0;
  int           reqs = 0;
  int           n0;
  logic [7:0]   fx [4] = '{8'h41, 8'h40, 8'h80, 8'h10};
  wire logic    general_pin_2_in = general_pin_2_oe ? general_pin_2_out : mcu_data;
  fsk_ook_shaping_demod_sync u_fsk_ook_shaping_demod_sync (
    .sys_clk, .rst_n, .link_clk, .link_rst_n, .link_sample, .cfg, .fei_start, .general_pin_2_in,
    .general_pin_2_out, .general_pin_2_oe, .bit_clock_out, .general_pin_1_out(), .tx_mod_out,
    .pa_level_out, .rx_data_out, .fei_status
  );
  mcu_model u_mcu_model (.bit_clock_out, .alt, .level, .data_out(mcu_data));
  always #4 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;
  always #320 if (tog) fsk_v = ~fsk_v;
  always @(posedge link_clk) link_sample <= #1 '{rssi_v, fsk_v, ferr_v};
  always @(posedge bit_clock_out) reqs++;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge link_clk);
    #1 link_rst_n = 1'b1;
  end
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Settle, one start pulse, then a bounded wait for done
  task automatic freq_error_meter(logic [15:0] fe, logic sgn);
    logic signed [15:0] r;
    ferr_v = fe;
    tick(60);
    fei_start = 1'b1;
    tick(1);
    fei_start = 1'b0;
    for (int i = 0; i < 300 && fei_status.done !== 1'b1; i++)
      tick(1);
    r = fei_status.freq_error_result;
    chk("fei_done", fei_status.done, 1'b1);
    chk("fei_sign", r[15], sgn);
    chk("fei_unit", r % 100 == 0 && r != 0, 1'b1);
  endtask
  initial begin
    cfg = '0;
    cfg.onoff_slicer_type = SLICE_FIXED;
    cfg.bitrate_low_byte = 8'h28;
    tick(3);
    chk("rst_pa", pa_level_out, 8'h00);
    chk("rst_oe", general_pin_2_oe, 1'b0);
    tick(2);
    rst_n = 1'b1;
    tick(2);
    cfg.ook_mode = 1'b1;
    cfg.tx_enable = 1'b1;
    cfg.tx_shaping_setting = 1'b1;
    cfg.shaping_ctrl_field = SHAPE_BT1;
    level = 1'b1;
    tick(60);
    chk("pa_mid", pa_level_out inside {[8'h01:8'hFE]}, 1'b1);
    tick(500);
    chk("pa_top", pa_level_out, PA_LEVEL_MAX);
    level = 1'b0;
    tick(500);
    chk("pa_off", pa_level_out, 8'h00);
    cfg.tx_shaping_setting = 1'b0;
    level = 1'b1;
    tick(6);
    chk("pa_jump", pa_level_out, PA_LEVEL_MAX);
    cfg.ook_mode = 1'b0;
    level = 1'b0;
    tick(8);
    chk("mod_lo", tx_mod_out, 10'h3F8);
    level = 1'b1;
    tick(8);
    chk("mod_hi", tx_mod_out, 10'h008);
    cfg.tx_shaping_setting = 1'b1;
    alt = 1'b1;
    n0 = reqs;
    tick(480);
    chk("tx_req", reqs - n0 inside {[10:13]}, 1'b1);
    chk("bt1", tx_mod_out inside {10'h004, 10'h3FC}, 1'b1);
    cfg.shaping_ctrl_field = SHAPE_BT05;
    cfg.tx_enable = 1'b0;
    tick(2);
    cfg.tx_enable = 1'b1;
    tick(200);
    chk("bt05", tx_mod_out, 10'h000);
    cfg.tx_enable = 1'b0;
    cfg.ook_mode = 1'b1;
    cfg.sync_bypass = 1'b1;
    cfg.slicer_floor_level = 8'h40;
    foreach (fx[i]) begin
      rssi_v = fx[i];
      tick(80);
      chk("fixed", rx_data_out, fx[i] > 8'h40);
    end
    cfg.onoff_slicer_type = SLICE_PEAK;
    cfg.slicer_floor_level = 8'h60;
    cfg.peak_decay_step = 3'h1;
    cfg.peak_decay_period = 3'h7;
    rssi_v = 8'h80;
    tick(80);
    rssi_v = 8'h75;
    tick(60);
    chk("peak_in", rx_data_out, 1'b1);
    rssi_v = 8'h73;
    tick(60);
    chk("peak_lo", rx_data_out, 1'b0);
    cfg.peak_decay_period = 3'h0;
    rssi_v = 8'h65;
    tick(40);
    chk("decay0", rx_data_out, 1'b0);
    tick(6000);
    chk("decay1", rx_data_out, 1'b1);
    rssi_v = 8'h5F;
    tick(80);
    chk("floor", rx_data_out, 1'b0);
    cfg.onoff_slicer_type = SLICE_AVERAGE;
    cfg.slicer_floor_level = 8'h70;
    rssi_v = 8'h00;
    tick(1500);
    chk("avg_lo", rx_data_out, 1'b0);
    rssi_v = 8'h50;
    tick(60);
    chk("avg_hi", rx_data_out, 1'b1);
    cfg.ook_mode = 1'b0;
    cfg.sync_bypass = 1'b0;
    tog = 1'b1;
    tick(200);
    n0 = reqs;
    tick(1280);
    chk("sync_clk", reqs - n0 inside {[30:34]}, 1'b1);
    cfg.packet_mode = 1'b1;
    cfg.sync_bypass = 1'b1;
    tick(200);
    n0 = reqs;
    tick(1280);
    chk("pkt_clk", reqs - n0 inside {[30:34]}, 1'b1);
    freq_error_meter(16'hFE70, 1'b1);
    freq_error_meter(16'h0190, 1'b0);
    cfg.packet_mode = 1'b0;
    tog = 1'b0;
    fsk_v = 1'b1;
    tick(20);
    n0 = reqs;
    tick(200);
    chk("byp_clk", reqs, n0);
    chk("byp_data", rx_data_out, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
